// ===== hw/tmr8_waveform.sv
// 8-bit timer/counter with two compare channels and four count sequences.
// Assumes software strobes come from logic on core_clk; direction bits are levels.
`timescale 1ns/1ns
`default_nettype none
module tmr8_waveform (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Configuration
  input wire logic [2:0] wave_mode_sel,
  input wire logic [1:0] out_mode_sel_a,
  input wire logic [1:0] out_mode_sel_b,
  input wire logic [2:0] clk_sel,
  input wire logic prescale_reset,
  input wire logic dir_out_a,
  input wire logic dir_out_b,
  // Software access
  input wire tmr8_pkg::tmr8_wr_s wr,
  input wire tmr8_pkg::tmr8_fclr_s fclr,
  // Status
  output logic [7:0] count_value,
  output logic [7:0] compare_value_a,
  output logic [7:0] compare_value_b,
  output tmr8_pkg::tmr8_flags_s flags,
  // Pins
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_oe_a,
  output logic wave_oe_b
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_fast(input logic [2:0] m);
    return (m == tmr8_pkg::WM_FAST_FF) || (m == tmr8_pkg::WM_FAST_A);
  endfunction

  function automatic logic is_pc(input logic [2:0] m);
    return (m == tmr8_pkg::WM_PC_FF) || (m == tmr8_pkg::WM_PC_A);
  endfunction

  // Next output level for one channel
  function automatic logic out_next(input logic cur, input logic [2:0] m,
                                    input logic [1:0] om, input logic match,
                                    input logic up, input logic at_bottom_fast,
                                    input logic pc_bottom_fix);
    logic r;
    r = cur;
    if (om == tmr8_pkg::OM_OFF) begin
      r = cur;
    end else if (is_pc(m)) begin
      if (om != tmr8_pkg::OM_TOGGLE) begin
        if (match) begin
          r = (om == tmr8_pkg::OM_CLEAR) ? !up : up;
        end else if (pc_bottom_fix) begin
          r = (om == tmr8_pkg::OM_SET);
        end
      end
    end else if (is_fast(m)) begin
      if (om == tmr8_pkg::OM_TOGGLE) begin
        if (match) begin
          r = !cur;
        end
      end else if (match) begin
        r = (om == tmr8_pkg::OM_SET);
      end else if (at_bottom_fast) begin
        r = (om == tmr8_pkg::OM_CLEAR);
      end
    end else if (match) begin
      case (om)
        tmr8_pkg::OM_TOGGLE: r = !cur;
        tmr8_pkg::OM_CLEAR: r = 1'b0;
        default: r = 1'b1;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  logic [9:0] pre_cnt;
  logic [9:0] next_pre_cnt;
  logic tick;

  always_comb begin
    next_pre_cnt = pre_cnt + 10'h001;
    if (prescale_reset) begin
      next_pre_cnt = tmr8_pkg::PRE_RESET;
    end
    case (clk_sel)
      tmr8_pkg::CS_DIV1: tick = 1'b1;
      tmr8_pkg::CS_DIV8: tick = (pre_cnt & tmr8_pkg::PRE_M8) == tmr8_pkg::PRE_M8;
      tmr8_pkg::CS_DIV32: tick = (pre_cnt & tmr8_pkg::PRE_M32) == tmr8_pkg::PRE_M32;
      tmr8_pkg::CS_DIV64: tick = (pre_cnt & tmr8_pkg::PRE_M64) == tmr8_pkg::PRE_M64;
      tmr8_pkg::CS_DIV128: tick = (pre_cnt & tmr8_pkg::PRE_M128) == tmr8_pkg::PRE_M128;
      tmr8_pkg::CS_DIV256: tick = (pre_cnt & tmr8_pkg::PRE_M256) == tmr8_pkg::PRE_M256;
      tmr8_pkg::CS_DIV1024: tick = pre_cnt == tmr8_pkg::PRE_M1024;
      default: tick = 1'b0;
    endcase
    if (prescale_reset) begin
      tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt <= tmr8_pkg::PRE_RESET;
    end else if (clk_en) begin
      pre_cnt <= next_pre_cnt;
    end
  end

  // ----------------------------------------
  // Counter, compares, flags, outputs
  // ----------------------------------------
  tmr8_pkg::tmr8_dir_e dir;
  tmr8_pkg::tmr8_dir_e next_dir;
  logic [7:0] next_count;
  logic [7:0] buf_a;
  logic [7:0] buf_b;
  logic [7:0] next_buf_a;
  logic [7:0] next_buf_b;
  logic [7:0] next_cmp_a;
  logic [7:0] next_cmp_b;
  logic blk;
  logic next_blk;
  logic oc_a;
  logic oc_b;
  logic next_oc_a;
  logic next_oc_b;
  tmr8_pkg::tmr8_flags_s next_flags;
  logic [7:0] top;
  logic pwm;
  logic up;
  logic at_top;
  logic at_bottom;
  logic m_a;
  logic m_b;
  logic ovf_ev;
  logic load_buf;
  logic pc_fix_a;
  logic pc_fix_b;
  logic fast_bot;
  logic up_m;
  logic oc_a_seen;
  logic oc_b_seen;
  logic next_oc_a_seen;
  logic next_oc_b_seen;

  always_comb begin
    pwm = is_fast(wave_mode_sel) || is_pc(wave_mode_sel);
    top = tmr8_pkg::CNT_MAX;
    if (wave_mode_sel == tmr8_pkg::WM_FAST_A || wave_mode_sel == tmr8_pkg::WM_PC_A) begin
      top = compare_value_a;
    end
    up = (dir == tmr8_pkg::TMR8_UP);
    at_top = (count_value == top);
    at_bottom = (count_value == tmr8_pkg::CNT_BOTTOM);
    // Matches at the turning points count toward the coming slope
    up_m = up;
    if (is_pc(wave_mode_sel) && up && at_top) begin
      up_m = 1'b0;
    end else if (is_pc(wave_mode_sel) && !up && at_bottom) begin
      up_m = 1'b1;
    end
    m_a = tick && !blk && (count_value == compare_value_a);
    m_b = tick && !blk && (count_value == compare_value_b);
    next_count = count_value;
    next_dir = dir;
    ovf_ev = 1'b0;
    load_buf = 1'b0;
    fast_bot = 1'b0;
    pc_fix_a = 1'b0;
    pc_fix_b = 1'b0;
    if (tick) begin
      if (is_pc(wave_mode_sel)) begin
        if (up && at_top) begin
          next_dir = tmr8_pkg::TMR8_DOWN;
          next_count = count_value - 8'h01;
          load_buf = 1'b1;
        end else if (!up && at_bottom) begin
          next_dir = tmr8_pkg::TMR8_UP;
          next_count = count_value + 8'h01;
          ovf_ev = 1'b1;
          pc_fix_a = !oc_a_seen && (compare_value_a != top);
          pc_fix_b = !oc_b_seen && (compare_value_b != top);
        end else if (up) begin
          next_count = count_value + 8'h01;
        end else begin
          next_count = count_value - 8'h01;
        end
      end else begin
        next_dir = tmr8_pkg::TMR8_UP;
        if (is_fast(wave_mode_sel) && at_top) begin
          next_count = tmr8_pkg::CNT_BOTTOM;
          ovf_ev = 1'b1;
          load_buf = 1'b1;
          fast_bot = 1'b1;
        end else if (wave_mode_sel == tmr8_pkg::WM_CTC && m_a) begin
          next_count = tmr8_pkg::CNT_BOTTOM;
          ovf_ev = (count_value == tmr8_pkg::CNT_MAX);
        end else begin
          next_count = count_value + 8'h01;
          ovf_ev = (count_value == tmr8_pkg::CNT_MAX);
        end
      end
    end
    if (wr.cnt_we) begin
      next_count = wr.cnt_wdata;
    end
    next_blk = blk;
    if (wr.cnt_we) begin
      next_blk = 1'b1;
    end else if (tick) begin
      next_blk = 1'b0;
    end
    next_buf_a = wr.cmp_a_we ? wr.cmp_a_wdata : buf_a;
    next_buf_b = wr.cmp_b_we ? wr.cmp_b_wdata : buf_b;
    next_cmp_a = compare_value_a;
    next_cmp_b = compare_value_b;
    if (!pwm) begin
      next_cmp_a = next_buf_a;
      next_cmp_b = next_buf_b;
    end else if (load_buf) begin
      next_cmp_a = buf_a;
      next_cmp_b = buf_b;
    end
    next_oc_a = oc_a;
    next_oc_b = oc_b;
    if (tick) begin
      next_oc_a = out_next(oc_a, wave_mode_sel, out_mode_sel_a, m_a, up_m, fast_bot,
                           pc_fix_a);
      next_oc_b = out_next(oc_b, wave_mode_sel, out_mode_sel_b, m_b, up_m, fast_bot,
                           pc_fix_b);
    end
    // Set beats clear for every flag
    next_flags.overflow_flag = ovf_ev || (flags.overflow_flag && !fclr.clr_overflow);
    next_flags.match_flag_a = m_a || (flags.match_flag_a && !fclr.clr_match_a);
    next_flags.match_flag_b = m_b || (flags.match_flag_b && !fclr.clr_match_b);
  end

  // Up-count match seen since last bottom, per channel
  always_comb begin
    next_oc_a_seen = oc_a_seen;
    next_oc_b_seen = oc_b_seen;
    if (tick && !up && at_bottom) begin
      next_oc_a_seen = 1'b0;
      next_oc_b_seen = 1'b0;
    end else if (tick && up_m) begin
      next_oc_a_seen = oc_a_seen || m_a;
      next_oc_b_seen = oc_b_seen || m_b;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_value <= tmr8_pkg::CNT_BOTTOM;
      dir <= tmr8_pkg::TMR8_UP;
      buf_a <= tmr8_pkg::CNT_BOTTOM;
      buf_b <= tmr8_pkg::CNT_BOTTOM;
      compare_value_a <= tmr8_pkg::CNT_BOTTOM;
      compare_value_b <= tmr8_pkg::CNT_BOTTOM;
      blk <= 1'b0;
      oc_a <= 1'b0;
      oc_b <= 1'b0;
      oc_a_seen <= 1'b0;
      oc_b_seen <= 1'b0;
      flags <= '0;
    end else if (clk_en) begin
      count_value <= next_count;
      dir <= next_dir;
      buf_a <= next_buf_a;
      buf_b <= next_buf_b;
      compare_value_a <= next_cmp_a;
      compare_value_b <= next_cmp_b;
      blk <= next_blk;
      oc_a <= next_oc_a;
      oc_b <= next_oc_b;
      oc_a_seen <= next_oc_a_seen;
      oc_b_seen <= next_oc_b_seen;
      flags <= next_flags;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  assign wave_out_a = oc_a;
  assign wave_out_b = oc_b;
  assign wave_oe_a = dir_out_a;
  assign wave_oe_b = dir_out_b;
endmodule // tmr8_waveform
`default_nettype wire

// ===== hw/tmr8_pkg.sv
// Package for the 8-bit timer waveform-mode block.
// Assumes a single core clock; all users reference names with tmr8_pkg::.
package tmr8_pkg;
  // ----------------------------------------
  // Counter values and modes
  // ----------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_FF = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PC_A = 3'h5;
  localparam logic [2:0] WM_FAST_A = 3'h7;
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  // ----------------------------------------
  // Prescaler selections
  // ----------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;
  localparam logic [9:0] PRE_RESET = 10'h000;
  localparam logic [9:0] PRE_M8 = 10'h007;
  localparam logic [9:0] PRE_M32 = 10'h01F;
  localparam logic [9:0] PRE_M64 = 10'h03F;
  localparam logic [9:0] PRE_M128 = 10'h07F;
  localparam logic [9:0] PRE_M256 = 10'h0FF;
  localparam logic [9:0] PRE_M1024 = 10'h3FF;

  // Counter direction
  typedef enum logic [1:0] {
    TMR8_UP = 2'b01,
    TMR8_DOWN = 2'b10
  } tmr8_dir_e;

  // Software write strobes with data
  typedef struct packed {
    logic cnt_we;
    logic [7:0] cnt_wdata;
    logic cmp_a_we;
    logic [7:0] cmp_a_wdata;
    logic cmp_b_we;
    logic [7:0] cmp_b_wdata;
  } tmr8_wr_s;

  // Flag state
  typedef struct packed {
    logic overflow_flag;
    logic match_flag_a;
    logic match_flag_b;
  } tmr8_flags_s;

  // Flag clear strobes
  typedef struct packed {
    logic clr_overflow;
    logic clr_match_a;
    logic clr_match_b;
  } tmr8_fclr_s;
endpackage

// ===== verification/tmr8_waveform_props.sv
// Checker for the 8-bit timer waveform block, bound to its top module.
// Assumes counting checks are made only while the tick is undivided.
`timescale 1ns/1ns
`default_nettype none
module tmr8_waveform_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Control
  input wire logic clk_en,
  input wire logic [2:0] wave_mode_sel,
  input wire logic [1:0] out_mode_sel_a,
  input wire logic [2:0] clk_sel,
  input wire logic prescale_reset,
  input wire logic dir_out_a,
  input wire logic dir_out_b,
  input wire tmr8_pkg::tmr8_wr_s wr,
  // Status and pins
  input wire logic [7:0] count_value,
  input wire logic [7:0] compare_value_a,
  input wire tmr8_pkg::tmr8_flags_s flags,
  input wire logic wave_out_a,
  input wire logic wave_oe_a,
  input wire logic wave_oe_b
);
  // ------------------
  // Tick helpers
  // ------------------
  logic go;
  logic run;
  logic blk;
  logic hit;
  logic [2:0] m;
  logic [1:0] om;
  logic [7:0] c;
  assign go = clk_en && !prescale_reset && clk_sel == tmr8_pkg::CS_DIV1;
  assign run = go && !wr.cnt_we;
  assign hit = run && !blk && c == compare_value_a;
  assign m = wave_mode_sel;
  assign om = out_mode_sel_a;
  assign c = count_value;
  // Set by a count write, cleared by the next tick
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blk <= 1'b0;
    end else if (wr.cnt_we) begin
      blk <= 1'b1;
    end else if (go) begin
      blk <= 1'b0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ------------------
  // Assertions
  // ------------------
  a_oe_follows_dir: assert property (wave_oe_a == dir_out_a && wave_oe_b == dir_out_b)
    else $error("pin enable differs from direction");
  a_normal_step: assert property (run && m == 3'h0 |=> c == $past(c) + 8'h01)
    else $error("normal count did not step up");
  a_normal_overflow: assert property (run && m == 3'h0 && c == 8'hFF |=> flags.overflow_flag)
    else $error("normal wrap left overflow clear");
  a_ctc_clear: assert property (hit && m == 3'h2 |=> c == 8'h00)
    else $error("match did not clear count");
  a_ctc_toggle: assert property (hit && m == 3'h2 && om == 2'h1 |=> $changed(wave_out_a))
    else $error("match did not toggle output");
  a_off_hold: assert property (run && m == 3'h2 && om == 2'h0 |=> $stable(wave_out_a))
    else $error("output moved with action off");
  a_fast_wrap: assert property (run && m == 3'h3 && c == 8'hFF |=>
    c == 8'h00 && flags.overflow_flag)
    else $error("fast top did not wrap with overflow");
  a_fast_clear: assert property (hit && m == 3'h3 && om == 2'h2 && c != 8'hFF |=>
    !wave_out_a)
    else $error("fast match did not clear output");
  a_pc_top_hold: assert property (run && m == 3'h1 && c == 8'hFF |=> c == 8'hFE)
    else $error("top not left after one tick");
  a_pc_up_clear: assert property (hit && m == 3'h1 && om == 2'h2 && c != 8'hFF
    && $past(c) == c - 8'h01 |=> !wave_out_a)
    else $error("up-count match did not clear output");
  a_pc_bottom_ovf: assert property (run && !blk && m == 3'h1 && c == 8'h00
    && $past(c) == 8'h01 |=> c == 8'h01 && flags.overflow_flag)
    else $error("bottom turn without overflow");
  a_block_match: assert property (run && blk && c == compare_value_a
    && !flags.match_flag_a |=> !flags.match_flag_a)
    else $error("match after count write not blocked");
  c_ctc_match: cover property (hit && m == 3'h2);
  c_pc_top: cover property (run && m == 3'h1 && c == 8'hFF);
  c_block: cover property (run && blk && c == compare_value_a);
endmodule // tmr8_waveform_props
bind tmr8_waveform tmr8_waveform_props i_props (
  .core_clk, .nrst, .clk_en, .wave_mode_sel, .out_mode_sel_a, .clk_sel, .prescale_reset,
  .dir_out_a, .dir_out_b, .wr, .count_value, .compare_value_a, .flags, .wave_out_a,
  .wave_oe_a, .wave_oe_b
);
`default_nettype wire

// ===== verification/tmr8_waveform_tb.sv
// Self-checking bench for the 8-bit timer waveform block.
// Assumes the package is compiled first and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module tmr8_waveform_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] wave_mode_sel = 3'h0;
  logic [1:0] om = 2'h0;
  logic [2:0] clk_sel = 3'h1;
  logic prescale_reset = 1'b0;
  logic dir_a = 1'b0;
  logic clk_en = 1'b1;
  tmr8_pkg::tmr8_wr_s wr = '0;
  tmr8_pkg::tmr8_fclr_s fclr = '0;
  logic [7:0] count_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  tmr8_pkg::tmr8_flags_s flags;
  logic wave_out_a;
  logic wave_out_b;
  logic wave_oe_a;
  logic wave_oe_b;
  logic [7:0] ov_q[$];
  int per_q[$];
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int last = 0;
  logic ov_prev = 1'b0;
  logic wa_prev = 1'b0;
  int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [2:0] md[4] = '{3'h0, 3'h2, 3'h3, 3'h1};
  logic [7:0] st[4] = '{8'hFD, 8'hFC, 8'hFD, 8'h10};
  logic [7:0] ex[4] = '{8'h00, 8'h00, 8'h00, 8'h01};
  logic [2:0] pm[5] = '{3'h2, 3'h3, 3'h3, 3'h1, 3'h1};
  logic [1:0] po[5] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h3};
  int pp[5] = '{0, 256, 256, 510, 510};
  tmr8_waveform i_dut (
    .core_clk, .nrst, .clk_en, .wave_mode_sel, .out_mode_sel_a(om), .out_mode_sel_b(om),
    .clk_sel, .prescale_reset, .dir_out_a(dir_a), .dir_out_b(!dir_a), .wr, .fclr,
    .count_value, .compare_value_a, .compare_value_b, .flags, .wave_out_a,
    .wave_out_b, .wave_oe_a, .wave_oe_b
  );
  always #5 core_clk = !core_clk;
  // ------------------
  // Tasks
  // ------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic sw(input logic cw, input logic [7:0] c, input logic aw, input logic [7:0] a,
                    input logic [2:0] clr);
    wr <= '{cw, c, aw, a, 1'b0, 8'h00};
    fclr <= clr;
    tick(1);
    wr <= '0;
    fclr <= '0;
  endtask
  task automatic cmp_cnt(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_per(input string n, input int e, input int g);
    total_checks++;
    if (g != e) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic drain(input string n);
    int k;
    k = 0;
    while (ov_q.size() + per_q.size() > 0 && k < 3000) begin
      tick(1);
      k++;
    end
    if (k == 3000) begin
      mismatches++;
      $display("MISMATCH %s expected result seen none", n);
    end
    $display("test %s done", n);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ------------------
  // Result monitor
  // ------------------
  always @(negedge core_clk) begin
    cyc++;
    if (flags.overflow_flag === 1'b1 && ov_prev !== 1'b1 && ov_q.size() > 0) begin
      cmp_cnt("count_at_overflow", ov_q.pop_front(), count_value);
    end
    if (wave_out_a === 1'b1 && wa_prev !== 1'b1) begin
      if (per_q.size() > 0) begin
        cmp_per("out_period", per_q.pop_front(), cyc - last);
      end
      last = cyc;
    end
    ov_prev = flags.overflow_flag;
    wa_prev = wave_out_a;
  end
  initial begin
    #400000;
    mismatches++;
    $display("MISMATCH watchdog expected done seen timeout");
    summarize();
  end
  // ------------------
  // Stimulus
  // ------------------
  initial begin
    int c;
    int i;
    int n;
    logic [7:0] v;
    void'($urandom(32'h4145));
    tick(2);
    nrst <= 1'b1;
    prescale_reset <= 1'b1;
    tick(1);
    prescale_reset <= 1'b0;
    for (i = 1; i < 8; i++) begin
      clk_sel <= i[2:0];
      repeat (3) begin
        v = count_value;
        n = 0;
        do begin
          @(negedge core_clk);
          n++;
        end while (count_value === v && n < 3000);
      end
      cmp_per("tick_spacing", dv[i], n);
      tick(1);
    end
    $display("test prescale done");
    clk_sel <= tmr8_pkg::CS_DIV1;
    for (i = 0; i < 4; i++) begin
      wave_mode_sel <= md[i];
      sw(1'b1, st[i], 1'b1, 8'h20, 3'h0);
      tick(1);
      sw(1'b0, 8'h00, 1'b0, 8'h00, 3'b100);
      ov_q.push_back(ex[i]);
      drain("overflow");
    end
    for (i = 0; i < 5; i++) begin
      c = $urandom_range(254, 1);
      wave_mode_sel <= pm[i];
      om <= po[i];
      dir_a <= i[0];
      sw(1'b1, 8'h00, 1'b1, c[7:0], 3'h0);
      repeat (2) @(posedge wave_out_a);
      tick(1);
      per_q.push_back(i == 0 ? 2 * (c + 1) : pp[i]);
      drain("period");
    end
    wave_mode_sel <= tmr8_pkg::WM_CTC;
    om <= tmr8_pkg::OM_OFF;
    clk_sel <= tmr8_pkg::CS_STOP;
    sw(1'b1, 8'h40, 1'b1, 8'h40, 3'b111);
    clk_sel <= tmr8_pkg::CS_DIV1;
    tick(3);
    @(negedge core_clk);
    cmp_cnt("match_flag_a", 8'h00, {7'h00, flags.match_flag_a});
    cmp_cnt("count_after_block", 8'h43, count_value);
    tick(1);
    om <= tmr8_pkg::OM_TOGGLE;
    wr <= '{1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 8'h45};
    tick(1);
    wr <= '0;
    @(negedge core_clk);
    v = {7'h00, !wave_out_b};
    @(negedge core_clk);
    cmp_cnt("compare_value_b", 8'h45, compare_value_b);
    cmp_cnt("match_flag_b", 8'h01, {7'h00, flags.match_flag_b});
    cmp_cnt("wave_out_b", v, {7'h00, wave_out_b});
    @(posedge core_clk);
    clk_en <= 1'b0;
    tick(3);
    clk_en <= 1'b1;
    @(negedge core_clk);
    cmp_cnt("count_frozen", 8'h47, count_value);
    $display("test block done");
    summarize();
  end
endmodule // tmr8_waveform_tb
`default_nettype wire
